// file: rtl/overtemp_alert_output_bank_map.svh
/*
  Register map, reset values and field positions of the pin
  configuration and over-temperature limit bank.
  Assumes an 8-bit register address and 8-bit register data.
*/
`ifndef OVERTEMP_ALERT_OUTPUT_BANK_MAP_SVH
`define OVERTEMP_ALERT_OUTPUT_BANK_MAP_SVH

// Register byte offsets
`define ADDR_PIN_CFG3    8'h0a
`define ADDR_PIN_CFG4    8'h0b
`define ADDR_FACTORY     8'h0c
`define ADDR_INT_LIMIT   8'h0d
`define ADDR_REM1_LIMIT  8'h0e
`define ADDR_IRQ_STATUS  8'h40
`define ADDR_IRQ_MASK    8'h41
`define ADDR_PIN_DRIVE   8'h42
`define ADDR_PIN_LEVEL   8'h43

// Reset values
`define RST_PIN_CFG      8'h00
`define RST_INT_LIMIT    8'h37
`define RST_REM1_LIMIT   8'h50
`define RST_ZERO8        8'h00
`define RST_EVENTS       3'h0
`define RST_PREV_ACTIVE  8'hff

// Event bit positions in status and mask
`define EV_INT_OVER      0
`define EV_REM1_OVER     1
`define EV_PIN_ASSERT    2
`define EV_W             3

`endif

// file: rtl/overtemp_alert_output_bank_pkg.sv
/*
  Types shared by the limit bank and its pin cells.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package overtemp_alert_output_bank_pkg;

  // Per-pin configuration pair, direction in the even bit
  typedef struct packed {
    logic polarity;   // 1 = active high, 0 = active low
    logic direction;  // 1 = output, 0 = input
  } pin_cfg_s;

  // Register port request as one bundle
  typedef struct packed {
    logic [7:0] addr;   // Register byte offset
    logic [7:0] wdata;  // Write data
    logic       wr;     // One-cycle write strobe
    logic       rd;     // One-cycle read strobe
  } reg_req_s;

endpackage

// file: rtl/pin_cell.sv
/*
  One general-purpose pin: applies direction and polarity, drives
  the pin from flip-flops and reports its logical level.
  Assumes the pin input is synchronous to clk.
*/
`timescale 1ns/1ps
module pin_cell
  import overtemp_alert_output_bank_pkg::*;
(
  input  wire logic     clk,        // System clock
  input  wire logic     rst_b,      // Async reset, active low
  input  wire pin_cfg_s cfg,        // Direction and polarity
  input  wire logic     drive,      // Logical value to drive
  input  wire logic     pinIn,      // Level seen on the pin
  output logic          pinOut,     // Level driven on the pin
  output logic          pinOe,      // High while driving the pin
  output logic          active      // Logical (asserted) level
);

  // Polarity maps logical value to pin level both ways
  wire levelOut = cfg.polarity ? drive : ~drive;  // R02
  assign active = cfg.polarity ? pinIn : ~pinIn;  // R02

  // Pin drivers come from flip-flops, released at reset
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pinOut <= 1'b0;
      pinOe  <= 1'b0;
    end
    else
    begin
      pinOut <= levelOut;
      pinOe  <= cfg.direction;  // R01
    end
  end

  chk_dir_enable: assert property (  // R01
    @(posedge clk) disable iff (!rst_b)
    cfg.direction == 1'b1 |=> pinOe)
    else $error("pin not driven while set as output");

  chk_dir_input: assert property (  // R01
    @(posedge clk) disable iff (!rst_b)
    cfg.direction == 1'b0 |=> !pinOe)
    else $error("pin driven while set as input");

  chk_pol_drive: assert property (  // R02
    @(posedge clk) disable iff (!rst_b)
    drive |=> pinOut == $past(cfg.polarity))
    else $error("asserted output level ignores polarity");

endmodule

// file: rtl/overtemp_alert_output_limits_bank.sv
/*
  Pin configuration and over-temperature limit register bank.
  Holds direction and polarity for pins 8 to 15, the internal
  and first remote limits, an alert pin, and a sticky event status
  with mask and interrupt; the reserved factory register reads 0.
  Assumes a register master that keeps strobes one cycle long,
  never both at once, and temperature readings synchronous to clk.
*/
// Function
// R01 - Direction bit 0 input, 1 output
// R02 - Polarity bit 0 active low, 1 high
// R03 - Bank three: pin 8+n dir 2n, pol 2n+1
// R04 - Bank four pins 12-15, resets to zero
// R05 - Host never writes factory register
// R06 - Internal sensor limit, 8-bit host writable
// R07 - Exceeding limit asserts the alert pin
// R08 - Internal limit resets to 37h, 55 C
// R09 - Remote one limit resets to 50h, 80 C
// R10 - Remote one reading exceeding limit alerts
// R11 - One degree per bit, compared directly
`include "overtemp_alert_output_bank_map.svh"
`timescale 1ns/1ps
module overtemp_alert_output_limits_bank
  import overtemp_alert_output_bank_pkg::*;
#(
  parameter int PIN_COUNT = 8     // Pins 8 to 15
)
(
  input  wire logic                 clk,          // 40 MHz clock
  input  wire logic                 rst_b,        // Async reset, low
  input  wire reg_req_s             regReq,       // Register request
  output logic [7:0]                regRdata,     // Read data, +1 cycle
  input  wire logic [PIN_COUNT-1:0] pinIn,        // Pin levels in
  output logic [PIN_COUNT-1:0]      pinOut,       // Pin levels out
  output logic [PIN_COUNT-1:0]      pinOe,        // Pin drive enables
  input  wire logic [7:0]           intTemp,      // Internal reading
  input  wire logic [7:0]           remote1Temp,  // Remote one reading
  output logic                      overtempAlertB, // Alert, low active
  output logic                      irq           // Interrupt, level
);

  // Limits and readings are two's complement, one degree per bit,
  // so a signed compare is enough and no scaling is applied.
  function automatic logic exceeds(input logic [7:0] temp,
                                   input logic [7:0] limit);
    exceeds = $signed(temp) > $signed(limit);  // R11
  endfunction

  // Register decode of one strobe against one offset
  function automatic logic hit(input logic       strobe,
                               input logic [7:0] addr,
                               input logic [7:0] target);
    hit = strobe && (addr == target);
  endfunction

  // Software-visible state
  logic [7:0]           cfg3;        // Pins 8..11 configuration
  logic [7:0]           cfg4;        // Pins 12..15 configuration
  logic [7:0]           intLimit;    // Internal channel limit
  logic [7:0]           rem1Limit;   // Remote one channel limit
  logic [`EV_W-1:0]     status;      // Sticky event bits
  logic [`EV_W-1:0]     mask;        // Event enables
  logic [PIN_COUNT-1:0] pinDrive;    // Logical output values

  // Block state
  logic                 overInt;     // Internal over limit, held
  logic                 overRem;     // Remote one over limit, held
  logic [PIN_COUNT-1:0] activePrev;  // Logical pin levels, delayed
  logic [PIN_COUNT-1:0] pinActive;   // Logical pin levels now

  // Write decode, one wire per writable register
  wire wrCfg3   = hit(regReq.wr, regReq.addr, `ADDR_PIN_CFG3);
  wire wrCfg4   = hit(regReq.wr, regReq.addr, `ADDR_PIN_CFG4);
  wire wrInt    = hit(regReq.wr, regReq.addr, `ADDR_INT_LIMIT);
  wire wrRem1   = hit(regReq.wr, regReq.addr, `ADDR_REM1_LIMIT);
  wire wrStatus = hit(regReq.wr, regReq.addr, `ADDR_IRQ_STATUS);
  wire wrMask   = hit(regReq.wr, regReq.addr, `ADDR_IRQ_MASK);
  wire wrDrive  = hit(regReq.wr, regReq.addr, `ADDR_PIN_DRIVE);

  // The factory register has no storage and no write decode here,
  // so a stray write to it cannot change anything; it reads 0.

  // Both banks side by side; pin n owns bits 2n and 2n+1
  wire [2*PIN_COUNT-1:0] cfgBank = {cfg4, cfg3};  // R03 R04

  // Limit comparison, evaluated every cycle
  wire next_overInt = exceeds(intTemp, intLimit);      // R07
  wire next_overRem = exceeds(remote1Temp, rem1Limit); // R10

  // Events: a channel crossing its limit, or an input pin that
  // becomes asserted. Output pins are excluded as they echo drive.
  wire [PIN_COUNT-1:0] inputPins;
  wire evPin = |(pinActive & ~activePrev & inputPins);
  wire [`EV_W-1:0] events;
  assign events[`EV_INT_OVER]   = next_overInt & ~overInt;
  assign events[`EV_REM1_OVER]  = next_overRem & ~overRem;
  assign events[`EV_PIN_ASSERT] = evPin;

  // Write-one-to-clear; a new event in the same cycle wins
  wire [`EV_W-1:0] clrBits = wrStatus ? regReq.wdata[`EV_W-1:0]
                                      : `RST_EVENTS;
  wire [`EV_W-1:0] next_status = (status & ~clrBits) | events;

  // Read selection; unmapped offsets and the factory register read 0
  wire [7:0] statusWord = {{(8-`EV_W){1'b0}}, status};
  wire [7:0] maskWord   = {{(8-`EV_W){1'b0}}, mask};
  wire [7:0] readMux =
    (regReq.addr == `ADDR_PIN_CFG3)   ? cfg3 :
    (regReq.addr == `ADDR_PIN_CFG4)   ? cfg4 :
    (regReq.addr == `ADDR_INT_LIMIT)  ? intLimit :
    (regReq.addr == `ADDR_REM1_LIMIT) ? rem1Limit :
    (regReq.addr == `ADDR_IRQ_STATUS) ? statusWord :
    (regReq.addr == `ADDR_IRQ_MASK)   ? maskWord :
    (regReq.addr == `ADDR_PIN_DRIVE)  ? pinDrive :
    (regReq.addr == `ADDR_PIN_LEVEL)  ? pinActive :
                                        `RST_ZERO8;
  wire [7:0] next_regRdata = regReq.rd ? readMux : `RST_ZERO8;

  // One pin cell per pin, configured from its bit pair
  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++)
    begin : g_pin
      pin_cfg_s cellCfg;  // Pair for this pin
      assign cellCfg = pin_cfg_s'(cfgBank[2*gi +: 2]);  // R03 R04
      assign inputPins[gi] = ~cellCfg.direction;       // R01
      pin_cell u_cell (
        .clk    (clk),
        .rst_b  (rst_b),
        .cfg    (cellCfg),
        .drive  (pinDrive[gi]),
        .pinIn  (pinIn[gi]),
        .pinOut (pinOut[gi]),
        .pinOe  (pinOe[gi]),
        .active (pinActive[gi])
      );
    end
  endgenerate

  // Pin configuration banks, both cleared at reset
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cfg3 <= `RST_PIN_CFG;
      cfg4 <= `RST_PIN_CFG;  // R04
    end
    else
    begin
      if (wrCfg3)
        cfg3 <= regReq.wdata;  // R03
      if (wrCfg4)
        cfg4 <= regReq.wdata;  // R04
    end
  end

  // Limits load their power-on thresholds
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      intLimit  <= `RST_INT_LIMIT;   // R08
      rem1Limit <= `RST_REM1_LIMIT;  // R09
    end
    else
    begin
      if (wrInt)
        intLimit <= regReq.wdata;    // R06
      if (wrRem1)
        rem1Limit <= regReq.wdata;   // R10
    end
  end

  // Interrupt mask and pin drive values
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mask     <= `RST_EVENTS;
      pinDrive <= `RST_ZERO8;
    end
    else
    begin
      if (wrMask)
        mask <= regReq.wdata[`EV_W-1:0];
      if (wrDrive)
        pinDrive <= regReq.wdata;
    end
  end

  // Comparator state and the alert pin, high (idle) at reset
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      overInt        <= 1'b0;
      overRem        <= 1'b0;
      overtempAlertB <= 1'b1;
    end
    else
    begin
      overInt        <= next_overInt;
      overRem        <= next_overRem;
      overtempAlertB <= ~(next_overInt | next_overRem);  // R07 R10
    end
  end

  // Sticky status, pin history, interrupt and read data
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      status     <= `RST_EVENTS;
      // Seen as asserted: a pin already active at release is no event
      activePrev <= `RST_PREV_ACTIVE;
      irq        <= 1'b0;
      regRdata   <= `RST_ZERO8;
    end
    else
    begin
      status     <= next_status;
      activePrev <= pinActive;
      irq        <= |(next_status & mask);
      regRdata   <= next_regRdata;
    end
  end

  // Helpers that only the checks read: has a register been written
  logic seenCfg4;  // Bank four written since reset
  logic seenInt;   // Internal limit written since reset
  logic seenRem1;  // Remote limit written since reset
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      seenCfg4 <= 1'b0;
      seenInt  <= 1'b0;
      seenRem1 <= 1'b0;
    end
    else
    begin
      seenCfg4 <= seenCfg4 | wrCfg4;
      seenInt  <= seenInt | wrInt;
      seenRem1 <= seenRem1 | wrRem1;
    end
  end

  // Sequences: a pin configuration write, or a read of one offset
  sequence sWriteCfg3;
    wrCfg3;
  endsequence

  sequence sWriteCfg4;
    wrCfg4;
  endsequence

  sequence sLimitRead(logic [7:0] target);
    hit(regReq.rd, regReq.addr, target);
  endsequence

  chk_bank3_layout: assert property (  // R03
    @(posedge clk) disable iff (!rst_b)
    sWriteCfg3 |=> g_pin[1].cellCfg.polarity == $past(regReq.wdata[3])
               && g_pin[3].cellCfg.direction == $past(regReq.wdata[6]))
    else $error("bank three bit pairs misplaced");

  chk_bank4_layout: assert property (  // R04
    @(posedge clk) disable iff (!rst_b)
    sWriteCfg4 |=> g_pin[4].cellCfg.direction == $past(regReq.wdata[0])
               && g_pin[7].cellCfg.polarity == $past(regReq.wdata[7]))
    else $error("bank four bit pairs misplaced");

  chk_bank4_reset: assert property (  // R04
    @(posedge clk) disable iff (!rst_b)
    !seenCfg4 |-> cfg4 == `RST_PIN_CFG && pinOe[7:4] == 4'h0)
    else $error("bank four not zero after reset");

  chk_int_readback: assert property (  // R06
    @(posedge clk) disable iff (!rst_b)
    wrInt ##1 sLimitRead(`ADDR_INT_LIMIT)
      |=> regRdata == $past(regReq.wdata, 2))
    else $error("internal limit does not read back");

  chk_int_reset: assert property (  // R08
    @(posedge clk) disable iff (!rst_b)
    !seenInt |-> intLimit == `RST_INT_LIMIT)
    else $error("internal limit reset value wrong");

  chk_rem_reset: assert property (  // R09
    @(posedge clk) disable iff (!rst_b)
    !seenRem1 |-> rem1Limit == `RST_REM1_LIMIT)
    else $error("remote limit reset value wrong");

  chk_alert_int: assert property (  // R07
    @(posedge clk) disable iff (!rst_b)
    $signed(intTemp) > $signed(intLimit) |=> !overtempAlertB)
    else $error("alert missing on internal excess");

  chk_alert_rem: assert property (  // R10
    @(posedge clk) disable iff (!rst_b)
    $signed(remote1Temp) > $signed(rem1Limit) |=> !overtempAlertB)
    else $error("alert missing on remote excess");

  chk_alert_equal: assert property (  // R11
    @(posedge clk) disable iff (!rst_b)
    $signed(intTemp) <= $signed(intLimit)
      && $signed(remote1Temp) <= $signed(rem1Limit)
      |=> overtempAlertB)
    else $error("alert raised at or below the limit");

  chk_sticky_event: assert property (  // R07
    @(posedge clk) disable iff (!rst_b)
    events[`EV_INT_OVER] |=> status[`EV_INT_OVER]
      && (irq || !$past(mask[`EV_INT_OVER])))
    else $error("internal event lost or not signalled");

  chk_factory_quiet: assert property (  // R05
    @(posedge clk) disable iff (!rst_b)
    sLimitRead(`ADDR_FACTORY) |=> regRdata == `RST_ZERO8)
    else $error("factory register reads nonzero");

  chk_rem_readback: assert property (  // R10
    @(posedge clk) disable iff (!rst_b)
    wrRem1 ##1 sLimitRead(`ADDR_REM1_LIMIT)
      |=> regRdata == $past(regReq.wdata, 2))
    else $error("remote limit does not read back");

  chk_read_idle: assert property (  // R06
    @(posedge clk) disable iff (!rst_b)
    !regReq.rd |=> regRdata == `RST_ZERO8)
    else $error("read data stands without a read");

  chk_status_hold: assert property (  // R07
    @(posedge clk) disable iff (!rst_b)
    status[`EV_INT_OVER]
      && !(wrStatus && regReq.wdata[`EV_INT_OVER])
      |=> status[`EV_INT_OVER])
    else $error("internal status bit dropped without a clear");

  chk_status_clear: assert property (  // R10
    @(posedge clk) disable iff (!rst_b)
    wrStatus && regReq.wdata[`EV_REM1_OVER]
      && !events[`EV_REM1_OVER]
      |=> !status[`EV_REM1_OVER])
    else $error("remote status bit survives its clear");

  chk_pin_event: assert property (  // R01
    @(posedge clk) disable iff (!rst_b)
    inputPins[0] && $rose(pinActive[0])
      |=> status[`EV_PIN_ASSERT])
    else $error("input pin assertion raised no event");

endmodule

// file: bench/pin_world.sv
/*
  Far-side pin model: resolves each general pin from the block's
  drive enable and an outside source level.
  Assumes the outside level is set by the testbench.
*/
`timescale 1ns/1ps
module pin_world
#(
  parameter int PIN_COUNT = 8       // Pins modelled
)
(
  input  wire logic [PIN_COUNT-1:0] pinOut,   // Block drive level
  input  wire logic [PIN_COUNT-1:0] pinOe,    // Block drive enable
  input  wire logic [PIN_COUNT-1:0] extLevel, // Outside source level
  output logic      [PIN_COUNT-1:0] pinIn     // Resolved pin level
);
  // A driving block wins, so an output pin reads back its own level
  always_comb
  begin
    for (int i = 0; i < PIN_COUNT; i++)
      pinIn[i] = pinOe[i] ? pinOut[i] : extLevel[i];
  end
endmodule

// file: bench/testbench.sv
/*
  Self-checking bench for the pin configuration and limit bank.
  Assumes the register map header and the package of the design.
*/
`include "overtemp_alert_output_bank_map.svh"
`timescale 1ns/1ps
module testbench
  import overtemp_alert_output_bank_pkg::*;
;
  logic       clk;            // 40 MHz clock
  logic       rst_b;          // Reset, active low
  reg_req_s   regReq;         // Register request
  logic [7:0] regRdata;       // Read data
  logic [7:0] pinIn;          // Resolved pins
  logic [7:0] pinOut;         // Block pin levels
  logic [7:0] pinOe;          // Block drive enables
  logic [7:0] extLevel;       // Outside pin sources
  logic [7:0] intTemp;        // Internal reading
  logic [7:0] remote1Temp;    // Remote one reading
  logic       overtempAlertB; // Alert, active low
  logic       irq;            // Interrupt
  logic [7:0] expQ[$];        // Expected read data, oldest first
  logic       rdSeen = 1'b0;  // A read was taken last edge
  int         failures;       // Mismatch count
  int         comparisons;    // Comparison count

  overtemp_alert_output_limits_bank #(.PIN_COUNT(8)) DUT
  (
    .clk            (clk),
    .rst_b          (rst_b),
    .regReq         (regReq),
    .regRdata       (regRdata),
    .pinIn          (pinIn),
    .pinOut         (pinOut),
    .pinOe          (pinOe),
    .intTemp        (intTemp),
    .remote1Temp    (remote1Temp),
    .overtempAlertB (overtempAlertB),
    .irq            (irq)
  );

  pin_world #(.PIN_COUNT(8)) partner
  (
    .pinOut   (pinOut),
    .pinOe    (pinOe),
    .extLevel (extLevel),
    .pinIn    (pinIn)
  );

  // Free-running clock, 25 ns period
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Byte results: register data and pin vectors
  task automatic cmp8(input logic [7:0] act, input logic [7:0] exp);
    comparisons++;
    if (act !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t got %h want %h", $time, act, exp);
    end
  endtask

  // Single flag results: alert and interrupt
  task automatic cmp1(input logic act, input logic exp);
    comparisons++;
    if (act !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t got %h want %h", $time, act, exp);
    end
  endtask

  // Verdict and end of run, the only exit
  task automatic finish_test();
    if (failures == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic waitCyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One-cycle write strobe; a gap follows so strobes never merge
  task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regReq.addr  <= a;
    regReq.wdata <= d;
    regReq.wr    <= 1'b1;
    @(posedge clk);
    regReq.wr    <= 1'b0;
  endtask

  // One-cycle read strobe; the expectation is queued for the monitor
  task automatic rdReg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    regReq.addr <= a;
    regReq.rd   <= 1'b1;
    expQ.push_back(e);
    @(posedge clk);
    regReq.rd   <= 1'b0;
  endtask

  // Write then read the same offset back to back, with no gap
  task automatic wrThenRd(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regReq.addr  <= a;
    regReq.wdata <= d;
    regReq.wr    <= 1'b1;
    @(posedge clk);
    regReq.wr    <= 1'b0;
    regReq.rd    <= 1'b1;
    expQ.push_back(d);
    @(posedge clk);
    regReq.rd    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  always @(posedge clk)
  begin
    if (rdSeen && expQ.size() > 0)
      cmp8(regRdata, expQ.pop_front());
    rdSeen <= regReq.rd;
  end

  // Expected pin drive and levels from a 16-bit config pair
  task automatic checkPins(input logic [15:0] cfg, input logic [7:0] drv);
    logic [7:0] dir;
    logic [7:0] pol;
    for (int n = 0; n < 8; n++)
    begin
      dir[n] = cfg[2*n];
      pol[n] = cfg[2*n+1];
    end
    cmp8(pinOe, dir);
    cmp8(pinOut & dir, (drv ^ ~pol) & dir);
    rdReg(`ADDR_PIN_LEVEL, (dir & drv) | (~dir & ~(extLevel ^ pol)));
  endtask

  task automatic setTemp(input int ch, input logic [7:0] v);
    if (ch == 0)
      intTemp <= v;
    else
      remote1Temp <= v;
  endtask

  // Hang guard: a stuck run still reaches the verdict
  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    finish_test();
  end

  // Main sequence
  initial
  begin
    logic [15:0] cfg;
    logic [7:0]  drv;
    logic [7:0]  lim;
    logic [7:0]  bitSel;
    void'($urandom(72929));
    rst_b = 1'b0;
    regReq = '0;
    extLevel = 8'h00;
    intTemp = 8'h10;
    remote1Temp = 8'h10;
    failures = 0;
    comparisons = 0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    cmp1(overtempAlertB, 1'b1);
    cmp1(irq, 1'b0);
    cmp8(pinOe, 8'h00);
    // Power-on values; the reserved place is only ever read
    rdReg(`ADDR_PIN_CFG3, 8'h00);
    rdReg(`ADDR_PIN_CFG4, 8'h00);
    rdReg(`ADDR_INT_LIMIT, 8'h37);
    rdReg(`ADDR_REM1_LIMIT, 8'h50);
    rdReg(`ADDR_FACTORY, 8'h00);
    rdReg(8'h20, 8'h00);
    // Pins already asserted when reset ends raise no event
    rdReg(`ADDR_IRQ_STATUS, 8'h00);
    // All outputs low-active, all inputs high-active, then random
    for (int k = 0; k < 6; k++)
    begin
      cfg = (k == 0) ? 16'h5555 : (k == 1) ? 16'haaaa : 16'($urandom);
      drv = 8'($urandom);
      extLevel <= 8'($urandom);
      wrReg(`ADDR_PIN_CFG3, cfg[7:0]);
      wrReg(`ADDR_PIN_CFG4, cfg[15:8]);
      wrReg(`ADDR_PIN_DRIVE, drv);
      waitCyc(3);
      checkPins(cfg, drv);
      rdReg(`ADDR_PIN_CFG3, cfg[7:0]);
      rdReg(`ADDR_PIN_CFG4, cfg[15:8]);
      rdReg(`ADDR_PIN_DRIVE, drv);
    end
    // Input pin turning asserted raises the pin event
    wrReg(`ADDR_PIN_CFG3, 8'haa);
    wrReg(`ADDR_PIN_CFG4, 8'haa);
    extLevel <= 8'h00;
    waitCyc(3);
    wrReg(`ADDR_IRQ_STATUS, 8'h07);
    rdReg(`ADDR_IRQ_STATUS, 8'h00);
    extLevel <= 8'h01;
    waitCyc(3);
    rdReg(`ADDR_IRQ_STATUS, 8'h04);
    wrReg(`ADDR_IRQ_STATUS, 8'h04);
    // Each channel: equal is quiet, one degree over alerts
    for (int ch = 0; ch < 2; ch++)
    begin
      lim = 8'($urandom_range(8'h70, 8'h30));
      bitSel = 8'h01 << ch;
      wrThenRd(ch == 0 ? `ADDR_INT_LIMIT : `ADDR_REM1_LIMIT, lim);
      wrReg(`ADDR_IRQ_MASK, bitSel);
      rdReg(`ADDR_IRQ_MASK, bitSel);
      setTemp(ch, lim);
      waitCyc(3);
      cmp1(overtempAlertB, 1'b1);
      setTemp(ch, lim + 8'h01);
      waitCyc(2);
      cmp1(overtempAlertB, 1'b0);
      cmp1(irq, 1'b1);
      rdReg(`ADDR_IRQ_STATUS, bitSel);
      // Masking hides the sticky bit from the interrupt
      wrReg(`ADDR_IRQ_MASK, 8'h00);
      waitCyc(2);
      cmp1(irq, 1'b0);
      wrReg(`ADDR_IRQ_MASK, bitSel);
      waitCyc(2);
      cmp1(irq, 1'b1);
      setTemp(ch, lim);
      waitCyc(2);
      cmp1(overtempAlertB, 1'b1);
      cmp1(irq, 1'b1);
      wrReg(`ADDR_IRQ_STATUS, bitSel);
      waitCyc(2);
      cmp1(irq, 1'b0);
    end
    // Let the last read land, bounded
    for (int i = 0; i < 10 && expQ.size() > 0; i++)
      @(posedge clk);
    if (expQ.size() != 0)
      failures++;
    finish_test();
  end
endmodule
